// file: design/legacy_kbd_trap_smi.sv
// Legacy keyboard and mouse support: port 60h/64h traps, SMI and routing.
// Assumes configuration and I/O strobes are one-cycle and synchronous.
//
// Function
// RULE_01: Pass-through end status sticky, write one clears.
// RULE_02: Routing enable passes USB interrupt to line D.
// RULE_03: Reset value 2000h, routing enabled, all else off.
// RULE_04: USB interrupt status bit is read-only, live.
// RULE_05: Software clears USB interrupt inside USB controller.
// RULE_06: Sticky trap status per port and direction.
// RULE_07: Four enables turn on trapping and SMI.
// RULE_08: USB interrupt raises SMI when enabled.
// RULE_09: Sequence end raises SMI when enabled.
// RULE_10: Track D1h, data write, reads, FFh sequence.
// RULE_11: Deviation exits sequence and traps normally.
// RULE_12: No SMI while the sequence runs.
// RULE_13: Sequence accesses set no trap status.
// RULE_14: In-progress bit reads one during sequence.
// RULE_15: Clearing pass-through enable ends sequence at once.
// RULE_16: USB interrupt ORed with external line D.
// RULE_17: SMI asserted for any enabled set status.
`timescale 1ns/1ps
`default_nettype none
`include "lkts_consts.svh"

module legacy_kbd_trap_smi (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [1:0]  cfg_be,
  input  wire logic [15:0] cfg_wdata,
  output var  logic [15:0] cfg_rdata,
  input  wire logic        io_valid,
  input  wire logic        io_write,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        usb_irq,
  input  wire logic        shared_pci_irq_line_d_n,
  output var  logic        usb_irq_line_d,
  output var  logic        irq_line_d_to_pic,
  output var  logic        io_trap,
  output var  logic        system_mgmt_interrupt_n
);

  lkts_pkg::lkts_reg_t ctrl_r;
  lkts_pkg::lkts_reg_t ctrl_nxt;
  lkts_pkg::lkts_reg_t rdata_r;
  lkts_pkg::lkts_reg_t rdata_nxt;
  lkts_pkg::lkts_reg_t wmask;
  lkts_pkg::lkts_reg_t live;
  logic                smi_n_r;
  logic                smi_n_nxt;
  logic                trap_r;
  logic                trap_nxt;
  logic                line_d_r;
  logic                line_d_nxt;
  logic                pic_r;
  logic                pic_nxt;
  logic                written_r;
  logic                written_nxt;
  logic                hit;
  logic                is_cmd;
  logic                is_data;
  logic                kbd_valid;
  logic [3:0]          access;
  logic [3:0]          trap_set;
  logic                in_progress;
  logic                accepted;
  logic                seq_ended;
  logic                seq_aborted;
  logic                pt_en_nxt;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic logic port_match(input logic [15:0] a,
                                      input logic [15:0] p);
    port_match = (a == p);
  endfunction : port_match

  assign hit       = (cfg_addr == `LKTS_CTRL_OFFSET);
  assign is_cmd    = port_match(io_addr, `LKTS_CMD_PORT);
  assign is_data   = port_match(io_addr, `LKTS_DATA_PORT);
  assign kbd_valid = io_valid && (is_cmd || is_data);
  // Order matches status bits 11..8 and enable bits 3..0.
  assign access = {kbd_valid && is_cmd && io_write,
                   kbd_valid && is_cmd && !io_write,
                   kbd_valid && is_data && io_write,
                   kbd_valid && is_data && !io_write};

  // ----------------------------------------------------------------------
  // Pass-through sequence
  // ----------------------------------------------------------------------
  // The tracker sees the next value of the enable bit, built apart from
  // the full register so that no combinational loop runs through it.
  assign pt_en_nxt = (cfg_wr && hit && cfg_be[0]) ?
                     cfg_wdata[`LKTS_B_PT_EN] : ctrl_r[`LKTS_B_PT_EN];

  lkts_passthru_seq lkts_passthru_seq_inst (
    .clk         (clk),
    .rst_n       (rst_n),
    .enable      (pt_en_nxt),
    .io_valid    (kbd_valid),
    .io_write    (io_write),
    .io_is_cmd   (is_cmd),
    .io_wdata    (io_wdata),
    .in_progress (in_progress),
    .accepted    (accepted),
    .seq_ended   (seq_ended),
    .seq_aborted (seq_aborted)
  );

  // ----------------------------------------------------------------------
  // Control and status register
  // ----------------------------------------------------------------------
  // Byte enables gate each half, so a byte write never disturbs the
  // status or enables that live in the other byte.
  always_comb begin
    wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} &
            {16{cfg_wr && hit}};
    trap_set = access & ~{4{accepted}} &
               ctrl_r[`LKTS_B_TRAP_EN_LO +: 4]; // [RULE_07] [RULE_13]
    ctrl_nxt = (ctrl_r & ~(wmask & `LKTS_RW_MASK)) |
               (cfg_wdata & wmask & `LKTS_RW_MASK);
    // Write-one clears first, then hardware sets, so a set wins.
    ctrl_nxt = ctrl_nxt & ~(cfg_wdata & wmask & `LKTS_W1C_MASK); // [RULE_01]
    ctrl_nxt[`LKTS_B_TRAP_STS_LO +: 4] =
      ctrl_nxt[`LKTS_B_TRAP_STS_LO +: 4] | trap_set; // [RULE_06]
    if (seq_ended || seq_aborted) begin
      ctrl_nxt[`LKTS_B_PT_END_STS] = 1'b1; // [RULE_01]
    end
    written_nxt = written_r || (cfg_wr && hit);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= `LKTS_CTRL_RESET; // [RULE_03]
      written_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      written_r <= written_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Bit 12 and bit 6 are live views; writes to them are ignored because
  // they are left out of both write masks.
  always_comb begin
    live = ctrl_r;
    live[`LKTS_B_USB_IRQ_STS] = usb_irq; // [RULE_04] [RULE_05]
    live[`LKTS_B_PT_BUSY]     = in_progress; // [RULE_14]
    rdata_nxt = (cfg_rd && hit) ? live : 16'h0000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cfg_rdata = rdata_r;

  // ----------------------------------------------------------------------
  // SMI, trap indication and interrupt routing
  // ----------------------------------------------------------------------
  // The SMI output is a level over the sticky bits and the live USB interrupt; software deasserts it
  // by clearing status or enables, and the sequence holds it off.
  always_comb begin
    smi_n_nxt = !((|(ctrl_r[`LKTS_B_TRAP_STS_LO +: 4] &
                     ctrl_r[`LKTS_B_TRAP_EN_LO +: 4])) ||
                  (usb_irq && ctrl_r[`LKTS_B_SMI_USB_EN]) || // [RULE_08]
                  (ctrl_r[`LKTS_B_PT_END_STS] &&
                   ctrl_r[`LKTS_B_SMI_PT_END_EN])); // [RULE_09] [RULE_17]
    if (in_progress) begin
      smi_n_nxt = 1'b1; // [RULE_12]
    end
    trap_nxt   = |trap_set; // [RULE_11]
    line_d_nxt = usb_irq && ctrl_r[`LKTS_B_ROUTE_EN]; // [RULE_02]
    pic_nxt    = line_d_nxt || !shared_pci_irq_line_d_n; // [RULE_16]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smi_n_r  <= 1'b1;
      trap_r   <= 1'b0;
      line_d_r <= 1'b0;
      pic_r    <= 1'b0;
    end else begin
      smi_n_r  <= smi_n_nxt;
      trap_r   <= trap_nxt;
      line_d_r <= line_d_nxt;
      pic_r    <= pic_nxt;
    end
  end

  assign system_mgmt_interrupt_n = smi_n_r;
  assign io_trap                 = trap_r;
  assign usb_irq_line_d          = line_d_r;
  assign irq_line_d_to_pic       = pic_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_ptend_sticky: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rst_n)
    (ctrl_r[`LKTS_B_PT_END_STS] &&
     !(cfg_wr && hit && cfg_be[1] && cfg_wdata[`LKTS_B_PT_END_STS]))
    |=> ctrl_r[`LKTS_B_PT_END_STS])
    else $error("pass-through end status lost without a clear");

  a_route_line: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rst_n)
    ##1 usb_irq_line_d == $past(usb_irq && ctrl_r[`LKTS_B_ROUTE_EN]))
    else $error("line D routing does not follow the enable");

  a_reset_ctrl: assert property ( // [RULE_03]
    @(posedge clk) disable iff (!rst_n)
    !written_r |-> ((ctrl_r & `LKTS_TRAP_EN_MASK) == 16'h0000 &&
                    ctrl_r[`LKTS_B_ROUTE_EN]))
    else $error("control bits differ from reset value before any write");

  a_usbirq_read: assert property ( // [RULE_04]
    @(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit) |=> cfg_rdata[`LKTS_B_USB_IRQ_STS] == $past(usb_irq))
    else $error("USB interrupt status does not reflect the input");

  a_trap_sets: assert property ( // [RULE_06]
    @(posedge clk) disable iff (!rst_n)
    (access[3] && !accepted && ctrl_r[3])
    |=> ctrl_r[`LKTS_B_TRAP_STS_LO + 3] && io_trap)
    else $error("command port write trap not recorded");

  a_trap_off: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
    (access[0] && !ctrl_r[0] && !ctrl_r[`LKTS_B_TRAP_STS_LO])
    |=> !ctrl_r[`LKTS_B_TRAP_STS_LO])
    else $error("data port read trapped while disabled");

  a_usb_smi: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    (usb_irq && ctrl_r[`LKTS_B_SMI_USB_EN] && !in_progress)
    |=> !system_mgmt_interrupt_n)
    else $error("USB interrupt did not raise SMI");

  a_end_smi: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    (seq_ended && ctrl_r[`LKTS_B_SMI_PT_END_EN] &&
     !(cfg_wr && hit && cfg_be[0]))
    |=> ##1 (!system_mgmt_interrupt_n || $past(in_progress)))
    else $error("sequence end did not raise SMI");

  a_smi_quiet: assert property ( // [RULE_12]
    @(posedge clk) disable iff (!rst_n)
    in_progress |=> system_mgmt_interrupt_n)
    else $error("SMI asserted during pass-through sequence");

  a_no_trap_acc: assert property ( // [RULE_13]
    @(posedge clk) disable iff (!rst_n)
    accepted |=> ((ctrl_r[`LKTS_B_TRAP_STS_LO +: 4] &
                   ~$past(ctrl_r[`LKTS_B_TRAP_STS_LO +: 4])) == 4'h0 &&
                  !io_trap))
    else $error("sequence access set trap status");

  a_busy_clear: assert property ( // [RULE_15]
    @(posedge clk) disable iff (!rst_n)
    !ctrl_r[`LKTS_B_PT_EN] |-> !in_progress)
    else $error("sequence in progress while pass-through disabled");

  a_irq_or: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
    ##1 irq_line_d_to_pic == $past((usb_irq && ctrl_r[`LKTS_B_ROUTE_EN])
                                   || !shared_pci_irq_line_d_n))
    else $error("line D to interrupt controller is not the OR");

  a_en_next: assert property ( // [RULE_15]
    @(posedge clk) disable iff (!rst_n)
    ##1 ctrl_r[`LKTS_B_PT_EN] == $past(pt_en_nxt))
    else $error("tracker enable differs from the stored bit");

  a_end_status: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rst_n)
    (seq_ended || seq_aborted) |=> ctrl_r[`LKTS_B_PT_END_STS])
    else $error("sequence exit did not set end status");

  a_abort_trap: assert property ( // [RULE_11]
    @(posedge clk) disable iff (!rst_n)
    (seq_aborted && (|(access & ctrl_r[`LKTS_B_TRAP_EN_LO +: 4]))) |=> io_trap)
    else $error("deviating access was not trapped");

  a_busy_read: assert property ( // [RULE_14]
    @(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit) |=> cfg_rdata[`LKTS_B_PT_BUSY] == $past(in_progress))
    else $error("in-progress bit does not reflect the tracker");

  a_read_trap: assert property ( // [RULE_06]
    @(posedge clk) disable iff (!rst_n)
    (access[0] && !accepted && ctrl_r[`LKTS_B_TRAP_EN_LO])
    |=> ctrl_r[`LKTS_B_TRAP_STS_LO] && io_trap)
    else $error("data port read trap not recorded");

  a_trap_smi: assert property ( // [RULE_17]
    @(posedge clk) disable iff (!rst_n)
    ((|(ctrl_r[`LKTS_B_TRAP_STS_LO +: 4] &
        ctrl_r[`LKTS_B_TRAP_EN_LO +: 4])) && !in_progress)
    |=> !system_mgmt_interrupt_n)
    else $error("enabled trap status did not raise SMI");

  a_smi_idle: assert property ( // [RULE_17]
    @(posedge clk) disable iff (!rst_n)
    (!(|(ctrl_r[`LKTS_B_TRAP_STS_LO +: 4] &
         ctrl_r[`LKTS_B_TRAP_EN_LO +: 4])) &&
     !(usb_irq && ctrl_r[`LKTS_B_SMI_USB_EN]) &&
     !(ctrl_r[`LKTS_B_PT_END_STS] && ctrl_r[`LKTS_B_SMI_PT_END_EN]))
    |=> system_mgmt_interrupt_n)
    else $error("SMI asserted with no enabled source");

endmodule : legacy_kbd_trap_smi
`default_nettype wire

// file: design/lkts_consts.svh
// Constants for the legacy keyboard trap and SMI block.
// Assumes byte addressing of the configuration space and 16-bit host I/O.
`ifndef LKTS_CONSTS_SVH
`define LKTS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register placement and reset
// ----------------------------------------------------------------------
`define LKTS_CTRL_OFFSET     8'hc0
`define LKTS_CTRL_RESET      16'h2000
`define LKTS_RW_MASK         16'h20bf
`define LKTS_W1C_MASK        16'h8f00
`define LKTS_TRAP_EN_MASK    16'h00bf

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LKTS_B_PT_END_STS    15
`define LKTS_B_ROUTE_EN      13
`define LKTS_B_USB_IRQ_STS   12
`define LKTS_B_TRAP_STS_LO   8
`define LKTS_B_SMI_PT_END_EN 7
`define LKTS_B_PT_BUSY       6
`define LKTS_B_PT_EN         5
`define LKTS_B_SMI_USB_EN    4
`define LKTS_B_TRAP_EN_LO    0

// ----------------------------------------------------------------------
// Keyboard controller ports and command bytes
// ----------------------------------------------------------------------
`define LKTS_DATA_PORT       16'h0060
`define LKTS_CMD_PORT        16'h0064
`define LKTS_GATE_CMD        8'hd1
`define LKTS_GATE_END        8'hff

`endif

// file: design/lkts_pkg.sv
// Types shared by the legacy keyboard trap and SMI block.
// Assumes the constants header is compiled alongside.
package lkts_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PT_IDLE,
    PT_CMD,
    PT_DATA
  } lkts_pt_state_t;

  typedef logic [15:0] lkts_reg_t;

endpackage : lkts_pkg

// file: design/lkts_passthru_seq.sv
// Tracker for the address-line gate pass-through command sequence.
// Assumes io_valid marks one cycle per access to port 60h or 64h only.
`timescale 1ns/1ps
`default_nettype none
`include "lkts_consts.svh"

module lkts_passthru_seq (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       io_valid,
  input  wire logic       io_write,
  input  wire logic       io_is_cmd,
  input  wire logic [7:0] io_wdata,
  output var  logic       in_progress,
  output var  logic       accepted,
  output var  logic       seq_ended,
  output var  logic       seq_aborted
);

  lkts_pkg::lkts_pt_state_t state_r;
  lkts_pkg::lkts_pt_state_t state_nxt;

  // ----------------------------------------------------------------------
  // Sequence tracking
  // ----------------------------------------------------------------------
  // Enable is the register's next value, so clearing it ends the sequence
  // at the same edge that stores the cleared bit.
  always_comb begin
    state_nxt   = state_r;
    accepted    = 1'b0;
    seq_ended   = 1'b0;
    seq_aborted = 1'b0;
    if (!enable) begin
      state_nxt = lkts_pkg::PT_IDLE; // [RULE_15]
    end else begin
      unique case (state_r)
        lkts_pkg::PT_IDLE: begin
          if (io_valid && io_write && io_is_cmd &&
              io_wdata == `LKTS_GATE_CMD) begin
            accepted  = 1'b1; // [RULE_10]
            state_nxt = lkts_pkg::PT_CMD;
          end
        end
        lkts_pkg::PT_CMD: begin
          if (io_valid && io_write && !io_is_cmd) begin
            accepted  = 1'b1; // [RULE_10]
            state_nxt = lkts_pkg::PT_DATA;
          end else if (io_valid) begin
            seq_aborted = 1'b1; // [RULE_11]
            state_nxt   = lkts_pkg::PT_IDLE;
          end
        end
        lkts_pkg::PT_DATA: begin
          if (io_valid && !io_write && io_is_cmd) begin
            accepted = 1'b1; // [RULE_10]
          end else if (io_valid && io_write && io_is_cmd &&
                       io_wdata == `LKTS_GATE_END) begin
            accepted  = 1'b1; // [RULE_10]
            seq_ended = 1'b1;
            state_nxt = lkts_pkg::PT_IDLE;
          end else if (io_valid) begin
            seq_aborted = 1'b1; // [RULE_11]
            state_nxt   = lkts_pkg::PT_IDLE;
          end
        end
        default: begin
          state_nxt = lkts_pkg::PT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= lkts_pkg::PT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign in_progress = (state_r != lkts_pkg::PT_IDLE); // [RULE_14]

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_seq_start: assert property ( // [RULE_10]
    @(posedge clk) disable iff (!rst_n)
    (!in_progress && enable && io_valid && io_write && io_is_cmd &&
     io_wdata == `LKTS_GATE_CMD) |=> (in_progress || !enable))
    else $error("gate command did not start the sequence");

  a_abort_exit: assert property ( // [RULE_11]
    @(posedge clk) disable iff (!rst_n)
    seq_aborted |-> !accepted ##1 !in_progress)
    else $error("deviating access did not leave the sequence");

endmodule : lkts_passthru_seq
`default_nettype wire

// file: sim/lkts_host_model.sv
// Host model: issues keyboard port cycles and owns the USB interrupt level.
// Assumes the bench raises req for one cycle, on rising edges only.
`timescale 1ns/1ps
`default_nettype none
`include "lkts_consts.svh"

module lkts_host_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic        req_cmd_port,
  input  wire logic [7:0]  req_data,
  input  wire logic        irq_set,
  input  wire logic        irq_clr,
  output var  logic        io_valid,
  output var  logic        io_write,
  output var  logic [15:0] io_addr,
  output var  logic [7:0]  io_wdata,
  output var  logic        usb_irq
);
  // ----------------------------------------------------------------------
  // One-cycle I/O strobe and interrupt level
  // ----------------------------------------------------------------------
  // Outside a cycle the qualifiers toggle, so a design that samples them
  // without io_valid sees garbage rather than a lucky stale value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_valid <= 1'b0;
      io_write <= 1'b0;
      io_addr  <= 16'h0000;
      io_wdata <= 8'h00;
      usb_irq  <= 1'b0;
    end else begin
      io_valid <= req;
      if (req) begin
        io_write <= req_write;
        io_addr  <= req_cmd_port ? `LKTS_CMD_PORT : `LKTS_DATA_PORT;
        io_wdata <= req_write ? req_data : ~io_wdata;
      end else begin
        io_write <= ~io_write;
        io_addr  <= ~io_addr;
        io_wdata <= ~io_wdata;
      end
      // The level drops only when software services the USB controller.
      if (irq_set) usb_irq <= 1'b1;
      else if (irq_clr) usb_irq <= 1'b0;
    end
  end
endmodule : lkts_host_model
`default_nettype wire

// file: sim/legacy_kbd_trap_smi_bench.sv
// Self-checking bench for the legacy keyboard trap and SMI block.
// Assumes the host model drives the I/O side and the bench the config side.
`timescale 1ns/1ps
`default_nettype none
`include "lkts_consts.svh"

module legacy_kbd_trap_smi_bench;
  logic        clk, rst_n, cfg_wr, cfg_rd, req, req_write, req_cmd_port;
  logic        irq_set, irq_clr, shared_n, io_valid, io_write, usb_irq;
  logic [7:0]  cfg_addr, req_data, io_wdata;
  logic [1:0]  cfg_be;
  logic [15:0] cfg_wdata, cfg_rdata, io_addr;
  logic        line_d, to_pic, io_trap, smi_n, trap_seen, smi_seen;
  int          err_total, cmp_count;

  legacy_kbd_trap_smi legacy_kbd_trap_smi_inst (
    .clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .io_valid(io_valid), .io_write(io_write),
    .io_addr(io_addr), .io_wdata(io_wdata), .usb_irq(usb_irq),
    .shared_pci_irq_line_d_n(shared_n), .usb_irq_line_d(line_d),
    .irq_line_d_to_pic(to_pic), .io_trap(io_trap),
    .system_mgmt_interrupt_n(smi_n));

  lkts_host_model lkts_host_model_inst (
    .clk(clk), .rst_n(rst_n), .req(req), .req_write(req_write),
    .req_cmd_port(req_cmd_port), .req_data(req_data), .irq_set(irq_set),
    .irq_clr(irq_clr), .io_valid(io_valid), .io_write(io_write),
    .io_addr(io_addr), .io_wdata(io_wdata), .usb_irq(usb_irq));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cfg_write(input logic [15:0] data,
                           input logic [1:0]  be = 2'h3);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= `LKTS_CTRL_OFFSET;
    cfg_be    <= be;
    cfg_wdata <= data;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    cfg_wdata <= ~data;
  endtask : cfg_write

  // Read data stands for exactly the cycle after the taking edge.
  task automatic rd_check(input logic [7:0] addr, input logic [15:0] exp);
    @(posedge clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= addr;
    @(posedge clk);
    cfg_rd   <= 1'b0;
    #1 check("ctrl_status", cfg_rdata, exp);
  endtask : rd_check

  task automatic io_acc(input logic wr, input logic cmd, input logic [7:0] d);
    @(posedge clk);
    req          <= 1'b1;
    req_write    <= wr;
    req_cmd_port <= cmd;
    req_data     <= d;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1 trap_seen = io_trap;
    @(posedge clk);
    #1 smi_seen = smi_n;
  endtask : io_acc

  task automatic irq_ctl(input logic set);
    @(posedge clk);
    irq_set <= set;
    irq_clr <= ~set;
    @(posedge clk);
    irq_set <= 1'b0;
    irq_clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : irq_ctl

  // ----------------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_total = 0; cmp_count = 0; rst_n = 1'b0; cfg_wr = 1'b0;
    cfg_rd = 1'b0; cfg_addr = 8'h00; cfg_be = 2'h0; cfg_wdata = 16'h0000;
    req = 1'b0; req_write = 1'b0; req_cmd_port = 1'b0; req_data = 8'h00;
    irq_set = 1'b0; irq_clr = 1'b0; shared_n = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_check(`LKTS_CTRL_OFFSET, 16'h2000);
    rd_check(8'hc2, 16'h0000);
    // Routing onto line D and the external OR.
    irq_ctl(1'b1);
    check("line_d", line_d, 16'h0001);
    check("to_pic", to_pic, 16'h0001);
    rd_check(`LKTS_CTRL_OFFSET, 16'h3000);
    cfg_write(16'h1000);
    rd_check(`LKTS_CTRL_OFFSET, 16'h1000);
    check("line_d", line_d, 16'h0000);
    check("to_pic", to_pic, 16'h0000);
    @(posedge clk);
    shared_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("to_pic", to_pic, 16'h0001);
    shared_n <= 1'b1;
    // USB interrupt as an SMI source, cleared inside the USB controller.
    cfg_write(16'h0010);
    repeat (2) @(posedge clk);
    #1 check("smi_n", smi_n, 16'h0000);
    irq_ctl(1'b0);
    check("smi_n", smi_n, 16'h0001);
    cfg_write(16'h0000);
    // A disabled port access leaves everything quiet.
    io_acc(1'b0, 1'b0, 8'h00);
    check("io_trap", trap_seen, 16'h0000);
    rd_check(`LKTS_CTRL_OFFSET, 16'h0000);
    // Each port and direction: i[0] selects write, i[1] the command port.
    for (int i = 0; i < 4; i++) begin
      cfg_write(16'h0001 << i);
      io_acc(i[0], i[1], 8'h5a);
      check("io_trap", trap_seen, 16'h0001);
      check("smi_n", smi_seen, 16'h0000);
      rd_check(`LKTS_CTRL_OFFSET, 16'h0101 << i);
      cfg_write(16'h0100 << i);
      rd_check(`LKTS_CTRL_OFFSET, 16'h0000);
    end
    // Full gate sequence with every trap enabled.
    cfg_write(16'h00af);
    io_acc(1'b1, 1'b1, `LKTS_GATE_CMD);
    check("io_trap", trap_seen, 16'h0000);
    rd_check(`LKTS_CTRL_OFFSET, 16'h00ef);
    io_acc(1'b1, 1'b0, 8'h3c);
    check("io_trap", trap_seen, 16'h0000);
    check("smi_n", smi_seen, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      io_acc(1'b0, 1'b1, 8'h00);
      check("io_trap", trap_seen, 16'h0000);
      check("smi_n", smi_seen, 16'h0001);
    end
    rd_check(`LKTS_CTRL_OFFSET, 16'h00ef);
    io_acc(1'b1, 1'b1, `LKTS_GATE_END);
    check("io_trap", trap_seen, 16'h0000);
    rd_check(`LKTS_CTRL_OFFSET, 16'h80af);
    check("smi_n", smi_n, 16'h0000);
    cfg_write(16'h00af);
    rd_check(`LKTS_CTRL_OFFSET, 16'h80af);
    cfg_write(16'h80af);
    rd_check(`LKTS_CTRL_OFFSET, 16'h00af);
    check("smi_n", smi_n, 16'h0001);
    // A data-port read in mid-sequence breaks out and traps.
    io_acc(1'b1, 1'b1, `LKTS_GATE_CMD);
    io_acc(1'b0, 1'b0, 8'h00);
    check("io_trap", trap_seen, 16'h0001);
    rd_check(`LKTS_CTRL_OFFSET, 16'h81af);
    check("smi_n", smi_n, 16'h0000);
    cfg_write(16'h81af);
    // Software disable ends a sequence without an end status.
    io_acc(1'b1, 1'b1, `LKTS_GATE_CMD);
    rd_check(`LKTS_CTRL_OFFSET, 16'h00ef);
    cfg_write(16'h008f);
    rd_check(`LKTS_CTRL_OFFSET, 16'h008f);
    io_acc(1'b1, 1'b0, 8'h3c);
    check("io_trap", trap_seen, 16'h0001);
    rd_check(`LKTS_CTRL_OFFSET, 16'h028f);
    // Byte lanes: the low byte holds the trap, SMI and pass-through enables, the high byte the status and the routing enable.
    cfg_write(16'h0f00, 2'h1);
    rd_check(`LKTS_CTRL_OFFSET, 16'h0200);
    cfg_write(16'h0fff, 2'h2);
    rd_check(`LKTS_CTRL_OFFSET, 16'h0000);
    print_verdict();
  end
endmodule : legacy_kbd_trap_smi_bench
`default_nettype wire
